// ### tic_pkg.sv
// ------------------------------------------------------------
// Shared constants for the timer and interrupt control core
// ------------------------------------------------------------
package tic_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_CNT = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0C;
  localparam logic [7:0] OFF_PSW = 8'h10;
  localparam logic [7:0] OFF_PORT = 8'h14;
  // Command codes written to the command register
  localparam logic [3:0] CMD_EXT_EN = 4'h1;
  localparam logic [3:0] CMD_EXT_DIS = 4'h2;
  localparam logic [3:0] CMD_TMR_EN = 4'h3;
  localparam logic [3:0] CMD_TMR_DIS = 4'h4;
  localparam logic [3:0] CMD_START_TIMER_OP = 4'h5;
  localparam logic [3:0] CMD_START_EVENT_COUNT_OP = 4'h6;
  localparam logic [3:0] CMD_STOP = 4'h7;
  localparam logic [3:0] CMD_JTF = 4'h8;
  localparam logic [3:0] CMD_CLKOUT = 4'h9;
  localparam logic [3:0] CMD_RETURN_WITH_STATUS_RESTORE = 4'hA;
  // Timing counts
  localparam int OSC_DIV = 3;
  localparam int STATES = 5;
  localparam int PRESC = 32;
  // Vectors and reset values
  localparam logic [11:0] VEC_EXT = 12'h003;
  localparam logic [11:0] VEC_TMR = 12'h007;
  localparam logic [11:0] PC_RST = 12'h000;
  localparam logic [2:0] SP_RST = 3'h0;
  localparam logic [7:0] PORT_RST = 8'hFF;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // Counter input selection
  typedef enum logic [1:0] {
    TIC_STOP = 2'b00,
    TIC_TIMER = 2'b01,
    TIC_EVENT = 2'b11
  } tic_mode_e;
  // Instruction sequencer
  typedef enum logic {
    TIC_RUN = 1'b0,
    TIC_RETURN_WITH_STATUS_RESTORE = 1'b1
  } tic_seq_e;
endpackage

// ### tic_core.sv
// Operation
// - Low interrupt pin level requests interrupt
// - Interrupt pin sampled at each address strobe
// - External accept jumps to 3, pushes state
// - One level; reopens at return second cycle
// - Return restores state, then rechecks requests
// - External wins; timer request kept pending
// - Timer accept jumps to 7, pushes state
// - Timer disable blocks overflow interrupts only
// - Eight-bit counter loaded and read by software
// - Reset stops counting, keeps count value
// - Wrap from maximum sets overflow, requests
// - Overflow jump tests then clears flag
// - Event mode counts low-high-low input cycles
// - Timer mode counts machine cycles over 32
// - State clock is oscillator over three
// - Five states per cycle, one strobe
// - Clock output enable drives test pin
// - Instructions take one or two cycles
// - Reset clears pc, sp, banks, floats bus
// - Reset disables interrupts, timer, flags
`timescale 1ns/1ps
`default_nettype none
module tic_core (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins
  input wire logic int_n,
  input wire logic event_input_pin,
  output logic test_zero_pin_o,
  output logic test_zero_pin_oe_n,
  output logic ale,
  output logic state_clk,
  // Bus and port state
  output logic data_bus_oe_n,
  output logic [7:0] port1_o,
  output logic [7:0] port2_o
);
  // ------------------------------------------------------------
  // Clock generation
  // ------------------------------------------------------------
  logic [1:0] ph_q; // Oscillator phase within a state
  logic [2:0] st_q; // State within a machine cycle
  logic tick; // Last oscillator phase of a state
  logic ale_tick; // Machine cycle boundary
  logic sclk_q; // State clock flop
  logic ale_q; // Strobe output flop
  assign tick = (ph_q == 2'(tic_pkg::OSC_DIV - 1));
  assign ale_tick = tick && (st_q == 3'(tic_pkg::STATES - 1));

  // Divide by three for the state clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_q <= 2'h0;
      sclk_q <= 1'b0;
    end else begin
      ph_q <= tick ? 2'h0 : ph_q + 2'h1;
      sclk_q <= tick; // High for the first phase of each state
    end
  end

  // Five states make one machine cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= 3'h0;
      ale_q <= 1'b0;
    end else begin
      if (tick) begin
        st_q <= ale_tick ? 3'h0 : st_q + 3'h1;
      end
      ale_q <= ale_tick; // One strobe per machine cycle
    end
  end
  assign ale = ale_q;
  assign state_clk = sclk_q;

  // ------------------------------------------------------------
  // Control state
  // ------------------------------------------------------------
  tic_pkg::tic_mode_e mode_q; // Counter input
  tic_pkg::tic_seq_e seq_q; // Return sequencing
  logic ext_en_q; // External interrupt enable
  logic tmr_en_q; // Timer interrupt enable
  logic clkout_q; // State clock on test pin
  logic in_hand_q; // Handler active
  logic tmr_req_q; // Latched timer request
  logic ovf_q; // Overflow flag
  logic jtf_hit_q; // Result of last overflow jump
  logic [3:0] pend_q; // Command waiting for a boundary
  logic [7:0] cnt_q; // Counter value
  logic [4:0] presc_q; // Machine cycle prescaler
  logic ev_hi_q; // High phase seen on event pin
  logic [11:0] pc_q; // Program counter
  logic [2:0] sp_q; // Stack pointer
  logic [3:0] psw_hi_q; // Carry, aux carry, flag 0, bank
  logic f1_q; // User flag 1
  logic mbank_q; // Memory bank select
  logic dbus_drv_q; // Data bus driven
  logic [7:0] p1_q; // Port 1 latch
  logic [7:0] p2_q; // Port 2 latch
  logic [15:0] stk [8]; // Return stack: psw high, pc
  // Bus decode
  logic wr_acc; // Write in access phase
  logic hit; // Address is mapped
  logic cmd_busy; // Command refused
  logic cnt_wr; // Load counter from bus
  // Events
  logic exec; // Pending command executes now
  logic inc; // Counter increment
  logic ovf_set; // Counter wraps
  logic ext_hit; // Qualified external request
  logic tmr_hit; // Qualified timer request
  logic can_acc; // Acceptance window open
  logic acc_ext; // External interrupt taken
  logic acc_tmr; // Timer interrupt taken
  logic jtf_exec; // Overflow jump executes

  assign wr_acc = psel && penable && pwrite;
  assign cmd_busy = (pend_q != 4'h0);
  assign cnt_wr = wr_acc && (paddr == tic_pkg::OFF_CNT);
  // Commands wait for a boundary; a return blocks them for its second cycle
  assign exec = ale_tick && cmd_busy && (seq_q == tic_pkg::TIC_RUN);
  assign jtf_exec = exec && (pend_q == tic_pkg::CMD_JTF);

  // ------------------------------------------------------------
  // Interrupt acceptance
  // ------------------------------------------------------------
  // Pin level is only looked at on the strobe boundary
  assign ext_hit = !int_n && ext_en_q;
  assign tmr_hit = tmr_req_q && tmr_en_q;
  // Window reopens at the start of the second return cycle
  assign can_acc = !in_hand_q || (seq_q == tic_pkg::TIC_RETURN_WITH_STATUS_RESTORE);
  assign acc_ext = ale_tick && can_acc && ext_hit;
  // External has priority; timer stays latched
  assign acc_tmr = ale_tick && can_acc && !ext_hit && tmr_hit;

  // Command latch from the bus
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_q <= 4'h0;
    end else if (wr_acc && paddr == tic_pkg::OFF_CMD && !cmd_busy) begin
      pend_q <= pwdata[3:0];
    end else if (exec) begin
      pend_q <= 4'h0;
    end
  end

  // Mode, enables and clock output
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= tic_pkg::TIC_STOP;
      ext_en_q <= 1'b0;
      tmr_en_q <= 1'b0;
      clkout_q <= 1'b0;
    end else if (exec) begin
      unique case (pend_q)
        tic_pkg::CMD_EXT_EN: ext_en_q <= 1'b1;
        tic_pkg::CMD_EXT_DIS: ext_en_q <= 1'b0;
        tic_pkg::CMD_TMR_EN: tmr_en_q <= 1'b1;
        tic_pkg::CMD_TMR_DIS: tmr_en_q <= 1'b0;
        tic_pkg::CMD_START_TIMER_OP: mode_q <= tic_pkg::TIC_TIMER;
        tic_pkg::CMD_START_EVENT_COUNT_OP: mode_q <= tic_pkg::TIC_EVENT;
        tic_pkg::CMD_STOP: mode_q <= tic_pkg::TIC_STOP;
        tic_pkg::CMD_CLKOUT: clkout_q <= 1'b1;
        default: begin
          // Other codes have no effect here
        end
      endcase
    end
  end

  // Return sequencer: each command is one cycle, return is two
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_q <= tic_pkg::TIC_RUN;
    end else if (ale_tick) begin
      unique case (seq_q)
        tic_pkg::TIC_RUN: begin
          if (exec && pend_q == tic_pkg::CMD_RETURN_WITH_STATUS_RESTORE) begin
            seq_q <= tic_pkg::TIC_RETURN_WITH_STATUS_RESTORE;
          end
        end
        tic_pkg::TIC_RETURN_WITH_STATUS_RESTORE: seq_q <= tic_pkg::TIC_RUN;
      endcase
    end
  end

  // Handler flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_hand_q <= 1'b0;
    end else if (acc_ext || acc_tmr) begin
      in_hand_q <= 1'b1;
    end else if (ale_tick && seq_q == tic_pkg::TIC_RETURN_WITH_STATUS_RESTORE) begin
      in_hand_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Timer and event counter
  // ------------------------------------------------------------
  // Prescaler runs on strobes even when stopped, keeping phase simple
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      presc_q <= 5'h0;
      ev_hi_q <= 1'b0;
    end else begin
      if (ale_tick) begin
        presc_q <= presc_q + 5'h1;
      end
      if (event_input_pin) begin
        ev_hi_q <= 1'b1;
      end else if (inc || mode_q != tic_pkg::TIC_EVENT) begin
        ev_hi_q <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (mode_q)
      tic_pkg::TIC_TIMER: inc = ale_tick && (presc_q == 5'(tic_pkg::PRESC - 1));
      tic_pkg::TIC_EVENT: inc = ev_hi_q && !event_input_pin;
      default: inc = 1'b0; // Stopped, or an illegal code
    endcase
  end
  assign ovf_set = inc && !cnt_wr && (cnt_q == tic_pkg::CNT_MAX);

  // Count is left alone by reset so it can resume
  always_ff @(posedge clk) begin
    if (cnt_wr) begin
      cnt_q <= pwdata[7:0];
    end else if (inc) begin
      cnt_q <= cnt_q + 8'h01; // Wraps to zero
    end
  end

  // Overflow flag, timer request and jump result
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovf_q <= 1'b0;
      tmr_req_q <= 1'b0;
      jtf_hit_q <= 1'b0;
    end else begin
      // Set wins over the clear of the same cycle
      if (ovf_set) begin
        ovf_q <= 1'b1;
      end else if (jtf_exec) begin
        ovf_q <= 1'b0;
      end
      if (jtf_exec) begin
        jtf_hit_q <= ovf_q;
      end
      // Disabled timer makes no request from overflow
      if (ovf_set && tmr_en_q) begin
        tmr_req_q <= 1'b1;
      end else if (acc_tmr) begin
        tmr_req_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Program counter, stack and status
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_q <= tic_pkg::PC_RST;
      sp_q <= tic_pkg::SP_RST;
      psw_hi_q <= 4'h0;
    end else if (acc_ext || acc_tmr) begin
      // Vector and push together
      pc_q <= acc_ext ? tic_pkg::VEC_EXT : tic_pkg::VEC_TMR;
      sp_q <= sp_q + 3'h1;
    end else if (exec && pend_q == tic_pkg::CMD_RETURN_WITH_STATUS_RESTORE) begin
      pc_q <= stk[sp_q - 3'h1][11:0];
      psw_hi_q <= stk[sp_q - 3'h1][15:12];
      sp_q <= sp_q - 3'h1;
    end else if (wr_acc && paddr == tic_pkg::OFF_PC) begin
      pc_q <= pwdata[11:0];
    end else if (wr_acc && paddr == tic_pkg::OFF_PSW) begin
      psw_hi_q <= pwdata[7:4];
    end
  end

  // Stack words; no reset needed for plain storage
  always_ff @(posedge clk) begin
    if (acc_ext || acc_tmr) begin
      stk[sp_q] <= {psw_hi_q, pc_q};
    end
  end

  // Flag 1, memory bank, ports and data bus
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      f1_q <= 1'b0;
      mbank_q <= 1'b0;
      dbus_drv_q <= 1'b0; // Bus floats
      p1_q <= tic_pkg::PORT_RST; // All ones is input mode
      p2_q <= tic_pkg::PORT_RST;
    end else if (wr_acc && paddr == tic_pkg::OFF_PSW) begin
      f1_q <= pwdata[8];
      mbank_q <= pwdata[9];
    end else if (wr_acc && paddr == tic_pkg::OFF_PORT) begin
      p1_q <= pwdata[7:0];
      p2_q <= pwdata[15:8];
      dbus_drv_q <= pwdata[16];
    end
  end
  assign data_bus_oe_n = !dbus_drv_q;
  assign port1_o = p1_q;
  assign port2_o = p2_q;

  // Test pin carries the state clock once enabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      test_zero_pin_o <= 1'b0;
      test_zero_pin_oe_n <= 1'b1;
    end else begin
      test_zero_pin_o <= clkout_q && tick;
      test_zero_pin_oe_n <= !clkout_q;
    end
  end

  // ------------------------------------------------------------
  // APB read path
  // ------------------------------------------------------------
  // Zero wait states; read data captured in the setup cycle
  assign pready = 1'b1;
  always_comb begin
    hit = 1'b1;
    unique case (paddr)
      tic_pkg::OFF_CMD, tic_pkg::OFF_CNT, tic_pkg::OFF_STAT: hit = 1'b1;
      tic_pkg::OFF_PC, tic_pkg::OFF_PSW, tic_pkg::OFF_PORT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  // Unmapped, or a command while one is still waiting
  assign pslverr = psel && penable && (!hit || (pwrite && paddr == tic_pkg::OFF_CMD && cmd_busy));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        tic_pkg::OFF_CMD: prdata <= {28'h0, pend_q};
        tic_pkg::OFF_CNT: prdata <= {24'h0, cnt_q};
        tic_pkg::OFF_STAT: prdata <= {22'h0, seq_q, in_hand_q, tmr_req_q, jtf_hit_q, ovf_q, clkout_q,
                                      mode_q, tmr_en_q, ext_en_q};
        tic_pkg::OFF_PC: prdata <= {20'h0, pc_q};
        tic_pkg::OFF_PSW: prdata <= {22'h0, mbank_q, f1_q, psw_hi_q, 1'b1, sp_q};
        tic_pkg::OFF_PORT: prdata <= {15'h0, dbus_drv_q, p2_q, p1_q};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_return_with_status_restore_start;
    exec && pend_q == tic_pkg::CMD_RETURN_WITH_STATUS_RESTORE;
  endsequence
  sequence s_second_cycle;
    ##14 (ale_tick && seq_q == tic_pkg::TIC_RETURN_WITH_STATUS_RESTORE);
  endsequence

  property p_state_div;
    tick |-> ##3 tick ##0 $past(!tick) ##0 $past(!tick, 2);
  endproperty
  a_state_div: assert property (p_state_div) else $error("state clock not osc over 3");

  property p_cycle_len;
    ale_tick |-> ##1 !ale_tick [*8] ##7 ale_tick;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("machine cycle not 15 clocks");

  property p_sample_edge;
    (acc_ext || acc_tmr) |-> ale_tick && st_q == 3'h4;
  endproperty
  a_sample_edge: assert property (p_sample_edge) else $error("accept off the strobe");

  property p_ext_vec;
    acc_ext |=> pc_q == tic_pkg::VEC_EXT && in_hand_q && sp_q == $past(sp_q) + 3'h1;
  endproperty
  a_ext_vec: assert property (p_ext_vec) else $error("external vector wrong");

  property p_tmr_vec;
    // A fresh overflow in the same cycle keeps the request, so leave that case out
    acc_tmr && !ovf_set |=> pc_q == tic_pkg::VEC_TMR && !tmr_req_q;
  endproperty
  a_tmr_vec: assert property (p_tmr_vec) else $error("timer vector wrong");

  property p_one_level;
    in_hand_q && seq_q == tic_pkg::TIC_RUN |-> !(acc_ext || acc_tmr);
  endproperty
  a_one_level: assert property (p_one_level) else $error("nested accept");

  property p_return_with_status_restore_pop;
    s_return_with_status_restore_start |=> pc_q == $past(stk[sp_q - 3'h1][11:0]) ##0 s_second_cycle ##1 (!in_hand_q || pc_q[2:0] == 3'h3
      || pc_q[2:0] == 3'h7);
  endproperty
  a_return_with_status_restore_pop: assert property (p_return_with_status_restore_pop) else $error("return sequence wrong");

  property p_prio;
    ale_tick && can_acc && ext_hit && tmr_hit |=> pc_q == tic_pkg::VEC_EXT && tmr_req_q;
  endproperty
  a_prio: assert property (p_prio) else $error("timer request lost");

  property p_tdis;
    !tmr_en_q && !tmr_req_q |=> !tmr_req_q;
  endproperty
  a_tdis: assert property (p_tdis) else $error("disabled timer requested");

  property p_wrap;
    inc && !cnt_wr && cnt_q == tic_pkg::CNT_MAX |=> cnt_q == 8'h00 && ovf_q;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap from max wrong");

  property p_jtf_clr;
    jtf_exec && !ovf_set |=> !ovf_q && jtf_hit_q == $past(ovf_q);
  endproperty
  a_jtf_clr: assert property (p_jtf_clr) else $error("jump did not clear flag");

  property p_tmr_rate;
    inc && mode_q == tic_pkg::TIC_TIMER |-> ale_tick && presc_q == 5'h1F;
  endproperty
  a_tmr_rate: assert property (p_tmr_rate) else $error("timer step off prescale");

  property p_event;
    mode_q == tic_pkg::TIC_EVENT && inc |-> $past(event_input_pin) && !event_input_pin;
  endproperty
  a_event: assert property (p_event) else $error("event count without cycle");

  property p_stop_hold;
    mode_q == tic_pkg::TIC_STOP && !cnt_wr |=> cnt_q == $past(cnt_q);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved");
endmodule
`default_nettype wire

// ### tic_partner.sv
`timescale 1ns/1ps
`default_nettype none
module tic_partner (
  // Clock
  input wire logic clk,
  // Pins toward the core
  output logic int_n,
  output var logic event_input_pin
);
  // ------------------------------
  // Interrupt sources and event source
  // ------------------------------
  // Two open-drain sources on one pulled-up line
  logic [1:0] src_n_q = 2'b11;
  // Any source pulling low wins the wire
  assign int_n = &src_n_q;
  // Event line rests low
  initial event_input_pin = 1'b0;
  // Pull or let go one source
  task automatic set_src(input int idx, input logic lvl);
    @(posedge clk);
    src_n_q[idx] <= lvl;
  endtask
  // One low-high-low event; high for 4 clk, then 45 clk of rest
  // Rest keeps at least three machine cycles per event
  task automatic pulse();
    @(posedge clk);
    event_input_pin <= 1'b1;
    repeat (4) @(posedge clk);
    event_input_pin <= 1'b0;
    repeat (45) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### tic_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tic_core_tb_top;
  // ------------------------------
  // Bench signals
  // ------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wire logic int_n;
  wire logic event_input_pin;
  logic test_zero_pin_o;
  logic test_zero_pin_oe_n;
  logic ale;
  logic state_clk;
  logic data_bus_oe_n;
  logic [7:0] port1_o;
  logic [7:0] port2_o;
  // Result of the last bus transfer
  logic [31:0] rd;
  logic er;
  // Strobe tallies and a kept count value
  logic [7:0] na;
  logic [7:0] ns;
  logic [7:0] v;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0;
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Free cycle count for interval checks
  always @(posedge clk) begin
    cyc <= cyc + 1;
  end
  // ------------------------------
  // Instances
  // ------------------------------
  tic_core i_tic_core (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .int_n(int_n),
    .event_input_pin(event_input_pin), .test_zero_pin_o(test_zero_pin_o),
    .test_zero_pin_oe_n(test_zero_pin_oe_n), .ale(ale), .state_clk(state_clk),
    .data_bus_oe_n(data_bus_oe_n), .port1_o(port1_o), .port2_o(port2_o));
  tic_partner i_tic_partner (.clk(clk), .int_n(int_n), .event_input_pin(event_input_pin));
  // ------------------------------
  // Tasks
  // ------------------------------
  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and stop
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Issue a command and poll until the core has taken it
  task automatic cmd(input logic [3:0] c);
    int n;
    apb(1'b1, tic_pkg::OFF_CMD, {28'h0, c});
    n = 0;
    do begin
      apb(1'b0, tic_pkg::OFF_CMD, 32'h0);
      n++;
    end while (rd[3:0] !== 4'h0 && n < 20);
    if (n >= 20) begin
      err_total++;
      end_of_test();
    end
  endtask
  // Read the status word
  task automatic st();
    apb(1'b0, tic_pkg::OFF_STAT, 32'h0);
  endtask
  // ------------------------------
  // Hang guard
  // ------------------------------
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    // Short reset; a board holds it far longer
    // Count has no reset value, so preload it while reset holds
    apb(1'b1, tic_pkg::OFF_CNT, 32'h0);
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, tic_pkg::OFF_PC, 32'h0);
    chk("pc", rd, 32'h0);
    apb(1'b0, tic_pkg::OFF_PSW, 32'h0);
    chk("psw", rd, 32'h8);
    st();
    chk("stat", rd, 32'h0);
    apb(1'b0, tic_pkg::OFF_PORT, 32'h0);
    chk("port", rd, 32'h0000FFFF);
    chk("port pins", {16'h0, port2_o, port1_o}, 32'h0000FFFF);
    chk("bus float", {31'h0, data_bus_oe_n}, 32'h1);
    chk("t0 off", {31'h0, test_zero_pin_oe_n}, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {31'h0, er}, 32'h1);
    // Tally strobes over ten machine cycles
    na = 8'h00;
    ns = 8'h00;
    repeat (150) begin
      @(posedge clk);
      na = na + {7'h0, ale};
      ns = ns + {7'h0, state_clk};
    end
    chk("ale count", {24'h0, na}, 32'd10);
    chk("state clk", {24'h0, ns}, 32'd50);
    // Event mode wrap with interrupts off
    cmd(tic_pkg::CMD_START_EVENT_COUNT_OP);
    apb(1'b1, tic_pkg::OFF_CNT, 32'hFE);
    apb(1'b0, tic_pkg::OFF_CNT, 32'h0);
    chk("load", rd, 32'hFE);
    i_tic_partner.pulse();
    i_tic_partner.pulse();
    apb(1'b0, tic_pkg::OFF_CNT, 32'h0);
    chk("wrap", rd, 32'h0);
    st();
    chk("ovf no req", {28'h0, rd[8:5]}, 32'h1);
    cmd(tic_pkg::CMD_JTF);
    st();
    chk("jump clr", {30'h0, rd[6:5]}, 32'h2);
    cmd(tic_pkg::CMD_JTF);
    st();
    chk("jump none", {30'h0, rd[6:5]}, 32'h0);
    // Timer interrupt disabled: wrap still counts, raises no request
    cmd(tic_pkg::CMD_TMR_EN);
    cmd(tic_pkg::CMD_TMR_DIS);
    apb(1'b1, tic_pkg::OFF_CNT, 32'hFF);
    i_tic_partner.pulse();
    st();
    chk("dis", {28'h0, rd[8:5]}, 32'h1);
    cmd(tic_pkg::CMD_JTF);
    // External first, timer kept, return hands over to it
    cmd(tic_pkg::CMD_EXT_EN);
    cmd(tic_pkg::CMD_TMR_EN);
    apb(1'b1, tic_pkg::OFF_PC, 32'h123);
    apb(1'b1, tic_pkg::OFF_PSW, 32'hA0);
    apb(1'b1, tic_pkg::OFF_CNT, 32'hFF);
    i_tic_partner.set_src(1, 1'b0);
    repeat (20) @(posedge clk);
    apb(1'b0, tic_pkg::OFF_PC, 32'h0);
    chk("ext vec", rd, 32'h3);
    apb(1'b0, tic_pkg::OFF_PSW, 32'h0);
    chk("push", {29'h0, rd[2:0]}, 32'h1);
    i_tic_partner.pulse();
    st();
    chk("held", {30'h0, rd[8:7]}, 32'h3);
    apb(1'b0, tic_pkg::OFF_PC, 32'h0);
    chk("no nest", rd, 32'h3);
    i_tic_partner.set_src(1, 1'b1);
    cmd(tic_pkg::CMD_RETURN_WITH_STATUS_RESTORE);
    repeat (20) @(posedge clk);
    apb(1'b0, tic_pkg::OFF_PC, 32'h0);
    chk("tmr vec", rd, 32'h7);
    cmd(tic_pkg::CMD_RETURN_WITH_STATUS_RESTORE);
    repeat (20) @(posedge clk);
    apb(1'b0, tic_pkg::OFF_PC, 32'h0);
    chk("ret pc", rd, 32'h123);
    apb(1'b0, tic_pkg::OFF_PSW, 32'h0);
    chk("ret psw", {24'h0, rd[7:0]}, 32'hA8);
    // External source switched off again
    cmd(tic_pkg::CMD_EXT_DIS);
    st();
    chk("ext off", {31'h0, rd[0]}, 32'h0);
    // Timer mode: one tick per 32 machine cycles (480 clk)
    cmd(tic_pkg::CMD_START_TIMER_OP);
    t0 = 0;
    for (int k = 0; k < 2; k++) begin
      apb(1'b0, tic_pkg::OFF_CNT, 32'h0);
      v = rd[7:0];
      for (int n = 0; n < 400 && rd[7:0] === v; n++) begin
        apb(1'b0, tic_pkg::OFF_CNT, 32'h0);
      end
      chk("tick step", {24'h0, rd[7:0]}, {24'h0, v + 8'h01});
      if (k == 1) begin
        chk("tick", {31'h0, (cyc - t0 >= 477 && cyc - t0 <= 483)}, 32'h1);
      end
      t0 = cyc;
    end
    // Stop command parks the mode; timer restarted after
    cmd(tic_pkg::CMD_STOP);
    st();
    chk("stopped", {30'h0, rd[3:2]}, 32'h0);
    cmd(tic_pkg::CMD_START_TIMER_OP);
    // Clock out, then a reset in mid-count
    cmd(tic_pkg::CMD_CLKOUT);
    chk("t0 on", {31'h0, test_zero_pin_oe_n}, 32'h0);
    ns = 8'h00;
    repeat (150) begin
      @(posedge clk);
      ns = ns + {7'h0, test_zero_pin_o};
    end
    chk("t0 clk", {24'h0, ns}, 32'd50);
    apb(1'b0, tic_pkg::OFF_CNT, 32'h0);
    v = rd[7:0];
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    chk("t0 reset", {31'h0, test_zero_pin_oe_n}, 32'h1);
    st();
    chk("stat reset", rd, 32'h0);
    repeat (600) @(posedge clk);
    apb(1'b0, tic_pkg::OFF_CNT, 32'h0);
    chk("kept", rd, {24'h0, v});
    end_of_test();
  end
endmodule
`default_nettype wire
